// ---- rtl/led_sink_pkg.sv ----
// Purpose: shared constants and types for the eight-channel LED sink control logic
// Assumes: one core clock; every pin is asynchronous to it
// Notes: the serial clock pin is sampled, not used as a clock
package led_sink_pkg;

	localparam int CHANNELS = 8;

	// reset values
	localparam logic [7:0] LATCH_RESET = 8'h00;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	localparam logic [7:0] SINK_RESET = 8'h00;
	// enable pin idles high, so the pulse history starts as all high samples
	localparam logic [2:0] EN_HIST_RESET = 3'h7;
	// pattern of the last three enable samples that marks a mode-switch pulse: high, low, high
	localparam logic [2:0] SWITCH_PULSE_PATTERN = 3'h5;
	// synchroniser start values, bit order {enable, strobe, serial data, serial clock}
	localparam logic [3:0] PIN_SYNC_INIT = 4'h8;
	localparam int PIN_EN_BIT = 3;
	localparam int PIN_STROBE_BIT = 2;
	localparam int PIN_DATA_BIT = 1;
	localparam int PIN_CLK_BIT = 0;

	// timing
	localparam int CORE_CLK_KHZ = 250000;
	localparam int SERIAL_CLK_MAX_KHZ = 25000;
	// core cycles in the shortest legal serial clock period
	localparam int SERIAL_PERIOD_CYCLES = CORE_CLK_KHZ / SERIAL_CLK_MAX_KHZ;

	typedef enum logic [1:0] {
		MODE_NORMAL,
		MODE_SWITCH,
		MODE_DETECT
	} mode_t;

endpackage

// ---- rtl/led_sink_shift_latch_detect.sv ----
// Purpose: serial-in parallel-out control of an eight-channel LED sink driver with open/short detection
// Assumes: all pins asynchronous to core_clk; serial clock at most 25 MHz against a 250 MHz core
// Notes: serial clock rising edges are found by sampling; analog sensing sits outside on err_*
//
// Behaviour
// RULE1: eight-bit shift register feeds an eight-bit output latch.
// RULE2: serial input pin enters the first shift stage on each shift.
// RULE3: shift register advances once per rising serial clock edge.
// RULE4: eight independent sink outputs, one per latch bit.
// RULE5: outside mode switching, strobe high makes the latch transparent. After mode switching the code keeps the latch closed until strobe has been low.
// RULE6: outside mode switching, strobe low holds the latch contents.
// RULE7: latch bit one sinks only while enable is low; zero stays off.
// RULE8: three phases: normal, mode switching, detection.
// RULE9: a one-clock low pulse on enable enters mode switching.
// RULE10: during mode switching the strobe never latches data, only selects mode.
// RULE11: in switching, strobe high selects detection, low selects normal.
// RULE12: in detection, enable low drives outputs and evaluates channel currents.
// RULE13: error results load into the shift register and shift out serially.
// RULE14: controller keeps the serial clock at or below 25 MHz.
// RULE15: enable high turns all outputs off in every phase.
// RULE16: serial output shows the last shift stage for cascading.
// RULE17: after reset: normal mode, latch cleared.
// RULE18: switch pulse is one low enable sample between two high samples.
`timescale 1ns/1ns
module led_sink_shift_latch_detect import led_sink_pkg::*; #(
	parameter int CH = CHANNELS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic strobe_select,
	input wire logic enable_switch_detect,
	output logic serial_out,
	output logic [CH-1:0] sink_channels,
	output logic detect_sense,
	input wire logic err_valid,
	output logic err_ready,
	input wire logic [CH-1:0] err_flags,
	output logic mode_detect,
	output logic mode_switching
);
	logic [3:0] pins_s;
	logic clk_s;
	logic data_s;
	logic strobe_s;
	logic en_s;
	logic clk_prev_q;
	logic sclk_rise;
	logic [2:0] en_hist_q;
	logic switch_pulse;
	mode_t mode_q;
	logic [CH-1:0] shift_q;
	logic [CH-1:0] latch_q;
	logic [CH-1:0] sink_q;
	logic detect_sense_q;
	logic err_buf_valid;
	logic [CH-1:0] err_buf_data;
	logic load_errors;
	logic err_take;
	logic strobe_armed_q;

	function automatic logic rises(input logic now_v, input logic was_v);
		rises = now_v && !was_v;
	endfunction

	pin_sync #(
		.W(4),
		.INIT(PIN_SYNC_INIT)
	) u_pin_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_d({enable_switch_detect, strobe_select, serial_in, serial_clk}),
		.pin_q(pins_s)
	);

	assign clk_s = pins_s[PIN_CLK_BIT];
	assign data_s = pins_s[PIN_DATA_BIT];
	assign strobe_s = pins_s[PIN_STROBE_BIT];
	assign en_s = pins_s[PIN_EN_BIT];

	// serial clock edge found in core domain; 25 MHz gives ten core cycles a period
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			clk_prev_q <= 1'b0;
		end else begin
			clk_prev_q <= clk_s;
		end
	end

	assign sclk_rise = rises(clk_s, clk_prev_q); // [RULE3] [RULE14]

	// enable sampled at each serial clock rising edge
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			en_hist_q <= EN_HIST_RESET;
		end else if (sclk_rise) begin
			en_hist_q <= {en_hist_q[1:0], en_s};
		end
	end

	// a longer low is plain output enable, not a switch request
	assign switch_pulse = ({en_hist_q[1:0], en_s} == SWITCH_PULSE_PATTERN); // [RULE18]

	// phase control
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_q <= MODE_NORMAL; // [RULE17]
		end else if (sclk_rise) begin
			case (mode_q)
				MODE_NORMAL, MODE_DETECT: begin
					if (switch_pulse) begin
						mode_q <= MODE_SWITCH; // [RULE9] [RULE8]
					end
				end
				MODE_SWITCH: begin
					// strobe level at the edge after the pulse picks the next mode
					if (switch_pulse) begin
						mode_q <= MODE_SWITCH;
					end else if (strobe_s) begin
						mode_q <= MODE_DETECT; // [RULE11]
					end else begin
						mode_q <= MODE_NORMAL; // [RULE11]
					end
				end
				default: begin
					mode_q <= MODE_NORMAL;
				end
			endcase
		end
	end

	// error words load while detection is enabled; otherwise the register shifts
	assign load_errors = sclk_rise && (mode_q == MODE_DETECT) && !en_s;
	assign err_take = load_errors && err_buf_valid;

	two_entry_buffer #(
		.W(CH)
	) u_err_buffer (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.in_valid(err_valid),
		.in_ready(err_ready),
		.in_data(err_flags),
		.out_valid(err_buf_valid),
		.out_ready(load_errors),
		.out_data(err_buf_data)
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_q <= SHIFT_RESET;
		end else if (err_take) begin
			shift_q <= err_buf_data; // [RULE13]
		end else if (sclk_rise) begin
			shift_q <= {shift_q[CH-2:0], data_s}; // [RULE1] [RULE2] [RULE3]
		end
	end

	// the strobe level that picked a mode must not latch once the new mode starts
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			strobe_armed_q <= 1'b1;
		end else if (mode_q == MODE_SWITCH) begin
			strobe_armed_q <= 1'b0; // [RULE10]
		end else if (!strobe_s) begin
			strobe_armed_q <= 1'b1;
		end
	end

	// latch follows the shift register one core cycle late while transparent
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			latch_q <= LATCH_RESET; // [RULE17]
		end else if (mode_q != MODE_SWITCH && strobe_s && strobe_armed_q) begin
			latch_q <= shift_q; // [RULE5] [RULE6] [RULE10] [RULE1]
		end
	end

	// gating uses the filtered enable, so blanking lags the pin by a few core cycles
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sink_q <= SINK_RESET;
		end else if (en_s) begin
			sink_q <= '0; // [RULE15]
		end else begin
			sink_q <= latch_q; // [RULE7] [RULE4] [RULE12]
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			detect_sense_q <= 1'b0;
		end else begin
			detect_sense_q <= (mode_q == MODE_DETECT) && !en_s; // [RULE12]
		end
	end

	assign sink_channels = sink_q;
	assign serial_out = shift_q[CH-1]; // [RULE16] [RULE13]
	assign detect_sense = detect_sense_q;
	assign mode_detect = (mode_q == MODE_DETECT);
	assign mode_switching = (mode_q == MODE_SWITCH);
endmodule // led_sink_shift_latch_detect

// ---- rtl/pin_sync.sv ----
// Purpose: three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: inputs change slower than two core cycles
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] pin_d,
	output logic [W-1:0] pin_q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
		end else begin
			s1_q <= pin_d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// per bit: a single-cycle disagreement never reaches the output
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q <= INIT;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					pin_q[i] <= s3_q[i];
				end
			end
		end
	end
endmodule // pin_sync

// ---- rtl/two_entry_buffer.sv ----
// Purpose: two-entry buffer with valid and ready on both sides
// Assumes: single clock
// Notes: in_ready is low only when both entries are full
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] head_q;
	logic [W-1:0] tail_q;
	logic [1:0] count_q;
	logic push;
	logic pop;

	assign in_ready = (count_q != 2'h2);
	assign out_valid = (count_q != 2'h0);
	assign out_data = head_q;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_q <= 2'h0;
		end else if (push && !pop) begin
			count_q <= count_q + 2'h1;
		end else if (pop && !push) begin
			count_q <= count_q - 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			head_q <= '0;
			tail_q <= '0;
		end else begin
			if (pop) begin
				head_q <= (count_q == 2'h2) ? tail_q : in_data;
			end else if (push && count_q == 2'h0) begin
				head_q <= in_data;
			end
			// when one entry drains while another arrives, the new word lands in head instead
			if (push && ((count_q == 2'h1 && !pop) || (count_q == 2'h2 && pop))) begin
				tail_q <= in_data;
			end
		end
	end
endmodule // two_entry_buffer

// ---- tb/err_source.sv ----
// Purpose: error word source in place of the analog sense side
// Assumes: valid held until ready is seen at a rising edge
// Notes: idle flags show the inverted last word
`timescale 1ns/1ns
module err_source (
	input wire logic core_clk,
	input wire logic err_ready,
	output logic err_valid,
	output logic [7:0] err_flags
);
	initial begin
		err_valid = 1'b0;
		err_flags = 8'h00;
	end
	task automatic push(input logic [7:0] w, output bit ok);
		ok = 1'b0;
		@(posedge core_clk);
		#1;
		err_valid = 1'b1;
		err_flags = w;
		for (int i = 0; i < 50 && !ok; i++) begin
			ok = (err_ready === 1'b1);
			@(posedge core_clk);
		end
		#1;
		err_valid = 1'b0;
		err_flags = ~w;
	endtask
endmodule // err_source

// ---- tb/led_sink_props.sv ----
// Purpose: port checks for the led sink control block
// Assumes: pins change slowly against core_clk
// Notes: serial edge age is counted from the raw pin
`timescale 1ns/1ns
module led_sink_props import led_sink_pkg::*; #(
	parameter int CH = CHANNELS
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic serial_clk,
	input wire logic serial_in,
	input wire logic strobe_select,
	input wire logic enable_switch_detect,
	input wire logic serial_out,
	input wire logic [CH-1:0] sink_channels,
	input wire logic detect_sense,
	input wire logic err_valid,
	input wire logic err_ready,
	input wire logic [CH-1:0] err_flags,
	input wire logic mode_detect,
	input wire logic mode_switching
);
	logic sclk_q;
	logic [7:0] age_q;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= serial_clk;
		end
	end
	// saturates so a long idle link never wraps back into the window
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			age_q <= 8'hff;
		end else if (serial_clk && !sclk_q) begin
			age_q <= 8'h00;
		end else if (age_q != 8'hff) begin
			age_q <= age_q + 8'h01;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	sequence en_idle; enable_switch_detect[*8]; endsequence
	sequence clk_quiet; (!serial_clk)[*8]; endsequence
	chk_blank_when_high: assert property (en_idle |-> sink_channels == '0)
		else $error("outputs on while enable high");
	chk_sense_off: assert property (en_idle |-> !detect_sense)
		else $error("sense while enable high");
	chk_sense_mode: assert property (detect_sense |-> $past(mode_detect))
		else $error("sense outside detection");
	chk_out_quiet: assert property (clk_quiet |=> $stable(serial_out))
		else $error("serial out moved without clock");
	chk_out_timing: assert property ($changed(serial_out) |-> age_q inside {[2:9]})
		else $error("serial out moved off a clock edge");
	chk_mode_timing: assert property ($changed({mode_detect, mode_switching}) |-> age_q inside {[2:9]})
		else $error("mode moved off a clock edge");
	chk_mode_excl: assert property (!(mode_detect && mode_switching))
		else $error("two phases at once");
	chk_ready_fall: assert property ($fell(err_ready) |-> $past(err_valid))
		else $error("buffer filled without a push");
	chk_ready_rise: assert property ($rose(err_ready) |-> age_q inside {[2:9]} && mode_detect)
		else $error("buffer drained off a clock edge");
endmodule // led_sink_props
bind led_sink_shift_latch_detect led_sink_props #(.CH(CH)) led_sink_props_i (.*);

// ---- tb/led_sink_shift_latch_detect_test.sv ----
// Purpose: self-checking bench for the led sink control block
// Assumes: serial clock of 12 core cycles, well under the limit
// Notes: every pin moves 1 ns after a core edge
`timescale 1ns/1ns
module led_sink_shift_latch_detect_test;
	logic core_clk = 1'b0;
	logic rst_b = 1'b0;
	logic sclk = 1'b0;
	logic sin = 1'b0;
	logic strobe = 1'b0;
	logic en = 1'b1;
	logic sout, sense, mdet, msw, ev, er;
	logic [7:0] sink, ef;
	int n_mismatch = 0;
	int tests_run = 0;
	bit ok;
	localparam logic [7:0] PAT_A = 8'ha5;
	localparam logic [7:0] PAT_B = 8'h3c;
	localparam logic [7:0] ERR_B = 8'hc3;
	always #2 core_clk = ~core_clk;
	led_sink_shift_latch_detect led_sink_shift_latch_detect_i (.core_clk(core_clk), .rst_b(rst_b),
		.serial_clk(sclk), .serial_in(sin), .strobe_select(strobe), .enable_switch_detect(en),
		.serial_out(sout), .sink_channels(sink), .detect_sense(sense), .err_valid(ev), .err_ready(er),
		.err_flags(ef), .mode_detect(mdet), .mode_switching(msw));
	err_source err_source_i (.core_clk(core_clk), .err_ready(er), .err_valid(ev), .err_flags(ef));
	task automatic summarize;
		$display("checks %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tick(logic d, logic s, logic e);
		sin = d;
		strobe = s;
		en = e;
		cyc(6);
		sclk = 1'b1;
		cyc(6);
		sclk = 1'b0;
	endtask
	task automatic push(logic [7:0] w);
		err_source_i.push(w, ok);
		if (!ok) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, ok, 1'b1);
			summarize();
		end
	endtask
	task automatic t_latch;
		for (int i = 7; i >= 0; i--) tick(PAT_A[i], 1'b0, 1'b0);
		cyc(4);
		chk({mdet, msw}, 8'h00);
		chk(sink, 8'h00);
		strobe = 1'b1;
		cyc(8);
		strobe = 1'b0;
		cyc(8);
		chk(sink, PAT_A);
		for (int i = 7; i >= 0; i--) begin
			chk({7'h0, sout}, {7'h0, PAT_A[i]});
			tick(PAT_B[i], 1'b0, 1'b0);
		end
		cyc(4);
		chk(sink, 8'ha5);
		en = 1'b1;
		cyc(8);
		chk(sink, 8'h00);
		en = 1'b0;
		cyc(8);
		chk(sink, 8'ha5);
	endtask
	task automatic t_detect;
		tick(1'b0, 1'b0, 1'b1);
		tick(1'b0, 1'b0, 1'b0);
		tick(1'b0, 1'b0, 1'b1);
		chk({mdet, msw}, 8'h01);
		tick(1'b0, 1'b1, 1'b1);
		strobe = 1'b0;
		chk({mdet, msw}, 8'h02);
		push(8'h5a);
		push(ERR_B);
		chk({7'h0, er}, 8'h00);
		tick(1'b0, 1'b0, 1'b0);
		chk({7'h0, er}, 8'h01);
		chk(sink, PAT_A);
		tick(1'b0, 1'b0, 1'b0);
		chk({sense, er}, 8'h03);
		for (int i = 7; i >= 0; i--) begin
			chk({7'h0, sout}, {7'h0, ERR_B[i]});
			tick(1'b1, 1'b0, 1'b1);
		end
		tick(1'b0, 1'b0, 1'b0);
		tick(1'b0, 1'b0, 1'b1);
		tick(1'b0, 1'b0, 1'b1);
		chk({mdet, msw, sense}, 8'h00);
	endtask
	initial begin
		repeat (3) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		cyc(6);
		chk({sink[0], sout, sense, mdet, msw, er}, 8'h01);
		t_latch();
		t_detect();
		summarize();
	end
endmodule // led_sink_shift_latch_detect_test
